// *** design/inset_geom_pkg.sv ***
// Constants for the inset picture geometry register bank.
// Assumes a serial-bus front end delivering decoded subaddress writes and reads.
// Function
// (R1) 9-bit line offset places first inset
// (R2) Override bit selects default or programmed value; the bank only passes the bit out and does not select
// (R3) Staged writes apply on operation-command write
// (R4) 9-bit vertical start, meaning per variant
// (R5) 9-bit line count, expert modes only
// (R6) 8-bit pixel count in four-pixel units
// (R7) Field buffer line length with override bit
// (R8) Host programs buffer length in expert mode
// (R9) Host writes zero to reserved bits
// (R10) Host never writes reserved subaddresses 8D-8F
// (R11) Operation command holds 2-bit x, y index
// (R12) New-command flag clears once setting applied
// (R13) Pixel offset in four-pixel units, with override
package inset_geom_pkg;
    localparam logic [7:0]  ADDR_LINE_OFFSET   = 8'h86;
    localparam logic [7:0]  ADDR_VERT_START    = 8'h87;
    localparam logic [7:0]  ADDR_LINE_COUNT    = 8'h88;
    localparam logic [7:0]  ADDR_PIXEL_OFFSET  = 8'h89;
    localparam logic [7:0]  ADDR_HORIZ_START   = 8'h8A;
    localparam logic [7:0]  ADDR_PIXEL_COUNT   = 8'h8B;
    localparam logic [7:0]  ADDR_FB_LINE_LEN   = 8'h8C;
    // Operation command kept clear of the reserved 8D-8F gap
    localparam logic [7:0]  ADDR_OPER_CMD      = 8'h7F;
    localparam int          NUM_GEOM           = 7;
    localparam logic [15:0] GEOM_RESET         = 16'h0000;
    localparam logic [7:0]  OPER_RESET         = 8'h00;
    // Writable bit masks; reserved bits read back as zero
    localparam logic [15:0] MASK_9BIT_OVR      = 16'h03FF;
    localparam logic [15:0] MASK_9BIT          = 16'h01FF;
    localparam logic [15:0] MASK_8BIT_OVR      = 16'h01FF;
    localparam logic [15:0] MASK_8BIT          = 16'h00FF;
    localparam int          OVR9_BIT           = 9;
    localparam int          OVR8_BIT           = 8;
    localparam int          IDX_X_LSB          = 0;
    localparam int          IDX_Y_LSB          = 2;
    localparam int          NEW_COMMAND_FLAG_BIT         = 7;
    // Cycles from operation-command write to applied settings
    localparam logic [3:0]  APPLY_CYCLES       = 4'h2;
endpackage

// *** design/staged_reg.sv ***
// One staged geometry register: shadow written by host, active loaded on apply.
// Assumes write and apply strobes are single-cycle, synchronous to clock_in.
`timescale 1ns/1ps
module staged_reg
    import inset_geom_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        enable_in,
    // Control
    input  wire logic        write_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        apply_in,
    // Values
    output logic      [15:0] shadow_out,
    output logic      [15:0] active_out
);
    typedef struct packed {
        logic [15:0] shadow;
        logic [15:0] active;
    } st_s;
    st_s st_ff;
    st_s nxt_st;

    // Stage host data; copy to active only on apply
    always_comb begin
        nxt_st = st_ff;
        if (write_in) begin
            nxt_st.shadow = wdata_in & MASK;
        end
        if (apply_in) begin
            nxt_st.active = st_ff.shadow; // R3
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '{shadow: GEOM_RESET, active: GEOM_RESET};
        end else if (enable_in) begin
            st_ff <= nxt_st;
        end
    end

    assign shadow_out = st_ff.shadow;
    assign active_out = st_ff.active;

    property p_apply_copies;
        @(posedge clock_in) disable iff (!nrst_in)
        (enable_in && apply_in) |=> (active_out == $past(shadow_out));
    endproperty
    a_apply_copies: assert property (p_apply_copies) // R3
        else $error("active value not loaded from shadow on apply");

    property p_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        !(enable_in && apply_in) |=> $stable(active_out);
    endproperty
    a_hold: assert property (p_hold) // R3
        else $error("active value changed without apply");
endmodule

// *** design/inset_picture_geometry_regs.sv ***
// Inset picture geometry register bank with staged update on operation command.
// Assumes a serial-bus slave front end presenting subaddress, data and strobes.
`timescale 1ns/1ps
module inset_picture_geometry_regs
    import inset_geom_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        enable_in,
    // Subaddress access from the serial bus front end
    input  wire logic [7:0]  subaddr_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic             rvalid_out,
    // Mode context
    input  wire logic        expert_in,
    // Applied geometry for the video pipeline
    output logic      [1:0]  inset_index_x_out,
    output logic      [1:0]  inset_index_y_out,
    output logic      [8:0]  inset_line_offset_out,
    output logic             line_offset_ext_out,
    output logic      [8:0]  inset_vertical_start_out,
    output logic             vertical_start_ext_out,
    output logic      [8:0]  inset_line_count_out,
    output logic      [7:0]  inset_pixel_offset_out,
    output logic             pixel_offset_ext_out,
    output logic      [7:0]  inset_horizontal_start_out,
    output logic      [7:0]  inset_pixel_count_out,
    output logic      [7:0]  field_buffer_line_length_out,
    output logic             fb_length_ext_out,
    output logic             apply_out
);
    localparam logic [15:0] MASKS [NUM_GEOM] = '{MASK_9BIT_OVR, MASK_9BIT_OVR, MASK_9BIT,
        MASK_8BIT_OVR, MASK_8BIT, MASK_8BIT, MASK_8BIT_OVR};

    typedef struct packed {
        logic [7:0]  oper;
        logic [3:0]  wait_cnt;
        logic        pending;
        logic [15:0] rdata;
        logic        rvalid;
        logic        apply;
        logic [1:0]  idx_x;
        logic [1:0]  idx_y;
        logic [8:0]  line_off;
        logic        line_ext;
        logic [8:0]  vstart;
        logic        vstart_ext;
        logic [8:0]  lines;
        logic [7:0]  pix_off;
        logic        pix_ext;
        logic [7:0]  hstart;
        logic [7:0]  pixels;
        logic [7:0]  fb_len;
        logic        fb_ext;
    } st_s;
    st_s st_ff;
    st_s nxt_st;

    logic [15:0] shadow [NUM_GEOM];
    logic [15:0] active [NUM_GEOM];
    logic        oper_wr;
    logic        copy_strobe;

    assign oper_wr     = wr_in && (subaddr_in == ADDR_OPER_CMD);
    assign copy_strobe = st_ff.pending && (st_ff.wait_cnt == 4'h0);

    // One staged register per geometry subaddress
    for (genvar g = 0; g < NUM_GEOM; g++) begin : g_reg
        staged_reg #(.MASK(MASKS[g])) u_reg (
            .clock_in   (clock_in),
            .nrst_in    (nrst_in),
            .enable_in  (enable_in),
            .write_in   (wr_in && (subaddr_in == ADDR_LINE_OFFSET + 8'(g))),
            .wdata_in   (wdata_in),
            .apply_in   (copy_strobe), // R3
            .shadow_out (shadow[g]),
            .active_out (active[g])
        );
    end

    // Command handling, readback and applied field decode
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.apply  = 1'b0;
        if (oper_wr) begin
            nxt_st.oper     = wdata_in[7:0];
            nxt_st.pending  = wdata_in[NEW_COMMAND_FLAG_BIT];
            nxt_st.wait_cnt = APPLY_CYCLES - 4'h1;
        end else if (st_ff.pending) begin
            if (st_ff.wait_cnt != 4'h0) begin
                nxt_st.wait_cnt = st_ff.wait_cnt - 4'h1;
            end else begin
                nxt_st.pending               = 1'b0;
                nxt_st.apply                 = 1'b1;
                nxt_st.oper[NEW_COMMAND_FLAG_BIT]      = 1'b0; // R12
                nxt_st.idx_x = st_ff.oper[IDX_X_LSB +: 2]; // R11
                nxt_st.idx_y = st_ff.oper[IDX_Y_LSB +: 2]; // R11
            end
        end
        if (rd_in) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = 16'h0000;
            if (subaddr_in == ADDR_OPER_CMD) begin
                nxt_st.rdata = {8'h00, st_ff.oper};
            end else if (subaddr_in >= ADDR_LINE_OFFSET && subaddr_in <= ADDR_FB_LINE_LEN) begin
                nxt_st.rdata = shadow[3'(subaddr_in - ADDR_LINE_OFFSET)];
            end
        end
        // Applied values; override bits are passed out beside their fields, not used to select
        nxt_st.line_off   = active[0][8:0];                      // R1
        nxt_st.line_ext   = active[0][OVR9_BIT];                 // R2
        nxt_st.vstart     = active[1][8:0];                      // R4
        nxt_st.vstart_ext = active[1][OVR9_BIT];                 // R2
        nxt_st.lines      = expert_in ? active[2][8:0] : 9'h000; // R5
        nxt_st.pix_off    = active[3][7:0];                      // R13
        nxt_st.pix_ext    = active[3][OVR8_BIT];                 // R2
        nxt_st.hstart     = active[4][7:0];
        nxt_st.pixels     = expert_in ? active[5][7:0] : 8'h00;  // R6
        nxt_st.fb_len     = active[6][7:0];                      // R7
        nxt_st.fb_ext     = active[6][OVR8_BIT];                 // R7
    end

    // State register
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff      <= '0;
            st_ff.oper <= OPER_RESET;
        end else if (enable_in) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_out                    = st_ff.rdata;
    assign rvalid_out                   = st_ff.rvalid;
    assign apply_out                    = st_ff.apply;
    assign inset_index_x_out            = st_ff.idx_x;
    assign inset_index_y_out            = st_ff.idx_y;
    assign inset_line_offset_out        = st_ff.line_off;
    assign line_offset_ext_out          = st_ff.line_ext;
    assign inset_vertical_start_out     = st_ff.vstart;
    assign vertical_start_ext_out       = st_ff.vstart_ext;
    assign inset_line_count_out         = st_ff.lines;
    assign inset_pixel_offset_out       = st_ff.pix_off;
    assign pixel_offset_ext_out         = st_ff.pix_ext;
    assign inset_horizontal_start_out   = st_ff.hstart;
    assign inset_pixel_count_out        = st_ff.pixels;
    assign field_buffer_line_length_out = st_ff.fb_len;
    assign fb_length_ext_out            = st_ff.fb_ext;

    sequence s_cmd;
        enable_in && oper_wr && wdata_in[NEW_COMMAND_FLAG_BIT] && !rd_in;
    endsequence
    sequence s_busy;
        (enable_in && !wr_in) [*2];
    endsequence

    property p_new_command_flag_clears;
        @(posedge clock_in) disable iff (!nrst_in)
        s_cmd ##1 s_busy |=> (st_ff.oper[NEW_COMMAND_FLAG_BIT] == 1'b0) && apply_out;
    endproperty
    a_new_command_flag_clears: assert property (p_new_command_flag_clears) // R12
        else $error("new command flag not cleared after apply");

    property p_index;
        @(posedge clock_in) disable iff (!nrst_in)
        $rose(apply_out) |-> inset_index_x_out == $past(st_ff.oper[1:0], 2);
    endproperty
    a_index: assert property (p_index) // R11
        else $error("x index not taken from command");

    property p_linecount_mode;
        @(posedge clock_in) disable iff (!nrst_in)
        !expert_in && $past(!expert_in) && $past(enable_in) |-> inset_line_count_out == 9'h000;
    endproperty
    a_linecount_mode: assert property (p_linecount_mode) // R5
        else $error("line count used outside expert mode");

    property p_pixcount_mode;
        @(posedge clock_in) disable iff (!nrst_in)
        !expert_in && $past(!expert_in) && $past(enable_in) |-> inset_pixel_count_out == 8'h00;
    endproperty
    a_pixcount_mode: assert property (p_pixcount_mode) // R6
        else $error("pixel count used outside expert mode");

    property p_line_ovr;
        @(posedge clock_in) disable iff (!nrst_in)
        $past(enable_in) |-> line_offset_ext_out == $past(active[0][OVR9_BIT]);
    endproperty
    a_line_ovr: assert property (p_line_ovr) // R2
        else $error("line offset override bit mismatch");

    property p_line_off;
        @(posedge clock_in) disable iff (!nrst_in)
        $past(enable_in) |-> inset_line_offset_out == $past(active[0][8:0]);
    endproperty
    a_line_off: assert property (p_line_off) // R1
        else $error("line offset field mismatch");

    property p_vstart;
        @(posedge clock_in) disable iff (!nrst_in)
        $past(enable_in) |-> inset_vertical_start_out == $past(active[1][8:0]);
    endproperty
    a_vstart: assert property (p_vstart) // R4
        else $error("vertical start field mismatch");

    property p_fb;
        @(posedge clock_in) disable iff (!nrst_in)
        $past(enable_in) |-> {fb_length_ext_out, field_buffer_line_length_out}
            == $past(active[6][8:0]);
    endproperty
    a_fb: assert property (p_fb) // R7
        else $error("field buffer length mismatch");

    property p_pixoff;
        @(posedge clock_in) disable iff (!nrst_in)
        $past(enable_in) |-> {pixel_offset_ext_out, inset_pixel_offset_out}
            == $past(active[3][8:0]);
    endproperty
    a_pixoff: assert property (p_pixoff) // R13
        else $error("pixel offset mismatch");
endmodule

// *** bench/inset_host.sv ***
// Serial-bus host model that issues subaddress writes and reads to the bank.
// Assumes the bank takes a request at a rising edge while the strobe is high.
`timescale 1ns/1ps
module inset_host
    import inset_geom_pkg::*;
(
    // Clock
    input  wire logic        clock_in,
    // Subaddress access
    output logic      [7:0]  subaddr_out,
    output logic             wr_out,
    output logic      [15:0] wdata_out,
    output logic             rd_out
);
    // Idle bus at time zero
    initial begin
        subaddr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 16'h0000;
        rd_out = 1'b0;
    end

    // Writable bits of each subaddress; the host keeps reserved bits at zero
    function automatic logic [15:0] msk(input logic [7:0] a);
        case (a)
            8'h86, 8'h87: msk = MASK_9BIT_OVR;
            8'h88:        msk = MASK_9BIT;
            8'h89, 8'h8C: msk = MASK_8BIT_OVR;
            default:      msk = MASK_8BIT;
        endcase
    endfunction

    // One write, held across one rising edge; data scrambled once released
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        if (a >= 8'h8D && a <= 8'h8F) return;
        @(negedge clock_in);
        subaddr_out = a;
        wdata_out = d & msk(a);
        wr_out = 1'b1;
        @(negedge clock_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask

    // One read strobe, held across one rising edge
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clock_in);
        subaddr_out = a;
        rd_out = 1'b1;
        @(negedge clock_in);
        rd_out = 1'b0;
    endtask
endmodule

// *** bench/inset_picture_geometry_regs_test.sv ***
// Self-checking bench for the inset geometry register bank.
// Assumes the host model in inset_host.sv drives the subaddress port.
`timescale 1ns/1ps
module inset_picture_geometry_regs_test
    import inset_geom_pkg::*;
;
    logic        clock_in;
    logic        nrst_in;
    logic        enable_in;
    logic        expert_in;
    logic        gpend;
    logic [31:0] seed;
    logic [7:0]  cmd;
    logic [15:0] wv [7];
    logic [66:0] gnow;
    logic [66:0] gq [$];
    logic [15:0] rq [$];
    int          n_errors;
    int          n_compared;
    wire  [7:0]  subaddr;
    wire         wr;
    wire         rd;
    wire         rvalid;
    wire  [15:0] wdata;
    wire  [15:0] rdata;
    wire  [66:0] geo;
    wire         gpend_src;
    // Line and pixel count fields, which follow the expert level at once
    localparam logic [66:0] CNT_MASK = 67'h7FC_0001_FE00;

    inset_host host (.clock_in(clock_in), .subaddr_out(subaddr), .wr_out(wr),
        .wdata_out(wdata), .rd_out(rd));

    inset_picture_geometry_regs uut (.clock_in(clock_in), .nrst_in(nrst_in),
        .enable_in(enable_in), .subaddr_in(subaddr), .wr_in(wr), .wdata_in(wdata),
        .rd_in(rd), .rdata_out(rdata), .rvalid_out(rvalid), .expert_in(expert_in),
        .inset_index_x_out(geo[66:65]), .inset_index_y_out(geo[64:63]),
        .inset_line_offset_out(geo[62:54]), .line_offset_ext_out(geo[53]),
        .inset_vertical_start_out(geo[52:44]), .vertical_start_ext_out(geo[43]),
        .inset_line_count_out(geo[42:34]), .inset_pixel_offset_out(geo[33:26]),
        .pixel_offset_ext_out(geo[25]), .inset_horizontal_start_out(geo[24:17]),
        .inset_pixel_count_out(geo[16:9]), .field_buffer_line_length_out(geo[8:1]),
        .fb_length_ext_out(geo[0]), .apply_out(gpend_src));

    // Clock of 5 ns period
    always #2.5 clock_in = ~clock_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction

    // Applied geometry expected from the staged words and the command byte
    function automatic logic [66:0] exp_geo(input logic [7:0] c, input logic x);
        exp_geo = {c[1:0], c[3:2], wv[0][8:0], wv[0][9], wv[1][8:0], wv[1][9],
            x ? wv[2][8:0] : 9'h000, wv[3][7:0], wv[3][8], wv[4][7:0],
            x ? wv[5][7:0] : 8'h00, wv[6][7:0], wv[6][8]};
    endfunction

    task automatic check(input string what, input logic [66:0] e, input logic [66:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
        rq.push_back(e);
        host.rd_reg(a);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Result watcher: oldest note is taken off its queue when a result appears
    always @(negedge clock_in) begin
        if (rvalid === 1'b1) begin
            check("rdata", {51'h0, rq.size() > 0 ? rq.pop_front() : 16'hXXXX}, {51'h0, rdata});
        end
        if (gpend) begin
            check("geometry", gq.size() > 0 ? gq.pop_front() : 'x, geo);
        end
        gpend = (gpend_src === 1'b1);
    end

    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        clock_in = 1'b0;
        nrst_in = 1'b0;
        enable_in = 1'b1;
        expert_in = 1'b0;
        gpend = 1'b0;
        seed = 32'hFC5C;
        n_errors = 0;
        n_compared = 0;
        gnow = 67'h0;
        repeat (8) @(negedge clock_in);
        nrst_in = 1'b1;
        check("reset geometry", 67'h0, geo);
        for (int i = 0; i < 7; i++) rd_exp(8'h86 + 8'(i), GEOM_RESET);
        rd_exp(ADDR_OPER_CMD, 16'h0000);
        rd_exp(8'h8D, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            // Stage random geometry, read it back, outputs must not move yet
            for (int i = 0; i < 7; i++) begin
                wv[i] = 16'(rnd()) & host.msk(8'h86 + 8'(i));
                if (i == 6 && k[0]) wv[i][8] = 1'b1;
                host.wr_reg(8'h86 + 8'(i), wv[i]);
            end
            for (int i = 0; i < 7; i++) rd_exp(8'h86 + 8'(i), wv[i]);
            check("staged", gnow, geo);
            cmd = {4'h8, 4'(rnd())};
            if (k == 2) begin
                // Command without the new-command flag applies nothing
                host.wr_reg(ADDR_OPER_CMD, {8'h00, 1'b0, cmd[6:0]});
                repeat (6) @(negedge clock_in);
                check("no apply", gnow, geo);
            end
            expert_in = k[0];
            gq.push_back(exp_geo(cmd, k[0]));
            host.wr_reg(ADDR_OPER_CMD, {8'h00, cmd});
            if (k == 1) begin
                // Clock enable low freezes the pending command and all outputs
                enable_in = 1'b0;
                repeat (5) @(negedge clock_in);
                check("frozen", gnow & ~CNT_MASK, geo & ~CNT_MASK);
                check("frozen apply", 67'h1, 67'(gq.size()));
                enable_in = 1'b1;
            end
            repeat (6) @(negedge clock_in);
            rd_exp(ADDR_OPER_CMD, {8'h00, 1'b0, cmd[6:0]});
            gnow = exp_geo(cmd, k[0]);
        end
        repeat (4) @(negedge clock_in);
        // Reset in mid-run returns the bank to its defaults
        nrst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        nrst_in = 1'b1;
        check("reset geometry", 67'h0, geo);
        rd_exp(ADDR_FB_LINE_LEN, GEOM_RESET);
        rd_exp(ADDR_OPER_CMD, 16'h0000);
        repeat (4) @(negedge clock_in);
        report_and_stop();
    end
endmodule
